// >>> arcc_cfg.svh
`ifndef ARCC_CFG_SVH
`define ARCC_CFG_SVH
// Register byte offsets
`define ARCC_SOUND_CONTROL_OFFSET 12'h000
`define ARCC_SOUND_STATUS_OFFSET 12'h004
`define ARCC_ADDR_WIDTH 12
// Command bit positions in sound_control
`define ARCC_RX_ENABLE_BIT 0
`define ARCC_RX_DISABLE_BIT 1
`define ARCC_CLK_ENABLE_BIT 2
`define ARCC_CLK_DISABLE_BIT 3
// Status bit positions in sound_status
`define ARCC_RX_ACTIVE_BIT 0
`define ARCC_CLK_ACTIVE_BIT 1
// Reset values of held states
`define ARCC_RX_ACTIVE_RESET 1'b0
`define ARCC_CLK_ACTIVE_RESET 1'b0
`endif

// >>> arcc_cmd_pair.sv
`timescale 1ns/100ps
// One held state driven by a pair of self-clearing command strobes
module arcc_cmd_pair (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_write,
   input wire logic i_enable_cmd,
   input wire logic i_disable_cmd,
   output logic o_state
);
   logic state_reg;
   logic state_next;
   arcc_pkg::arcc_cmd_t action;

   // Disable wins when both are written together
   assign action = !i_write ? arcc_pkg::ARCC_CMD_HOLD :
                   i_disable_cmd ? arcc_pkg::ARCC_CMD_CLEAR :
                   i_enable_cmd ? arcc_pkg::ARCC_CMD_SET : arcc_pkg::ARCC_CMD_HOLD;
   assign state_next = (action == arcc_pkg::ARCC_CMD_CLEAR) ? 1'b0 :
                       (action == arcc_pkg::ARCC_CMD_SET) ? 1'b1 : state_reg;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_state = state_reg;

   AST_PAIR_DISABLE_WINS: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      i_write && i_disable_cmd |=> !o_state) else $error("disable did not clear state");
   AST_PAIR_ZERO_HOLDS: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      !(i_write && (i_enable_cmd || i_disable_cmd)) |=> $stable(o_state))
      else $error("state changed without a command");
endmodule

// >>> arcc_codec_model.sv
`timescale 1ns/100ps
// Audio source stub: streams only while clocks run and the receiver is on
module arcc_codec_model (
   input wire logic i_sys_clk,
   input wire logic i_clock_gen_active,
   input wire logic i_receiver_active_flag,
   output logic [15:0] o_frames
);
   initial o_frames = 16'h0000;
   always @(posedge i_sys_clk) begin
      if (i_clock_gen_active && i_receiver_active_flag) begin
         o_frames <= o_frames + 16'h0001;
      end
   end
endmodule

// >>> arcc_pkg.sv
package arcc_pkg;
   // Action decoded from one enable/disable command pair
   typedef enum logic [1:0] {
      ARCC_CMD_HOLD = 2'b00,
      ARCC_CMD_SET = 2'b01,
      ARCC_CMD_CLEAR = 2'b11
   } arcc_cmd_t;
endpackage

// >>> arcc_top.sv
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "arcc_cfg.svh"
module arcc_top (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   output logic o_clock_gen_active,
   output logic o_receiver_active_flag
);
   logic access;
   logic hit_control;
   logic hit_status;
   logic ctrl_write;
   logic clock_gen_enable_cmd;
   logic clock_gen_disable_cmd;
   logic receiver_enable_cmd;
   logic receiver_disable_cmd;
   logic clk_state;
   logic rx_state;
   logic [31:0] status_word;
   logic rd_status;
   logic rd_control;
   logic wr_status;
   logic [31:0] prdata_next;
   logic pslverr_next;

   assign access = i_psel && i_penable;
   assign hit_control = (i_paddr == `ARCC_SOUND_CONTROL_OFFSET);
   assign hit_status = (i_paddr == `ARCC_SOUND_STATUS_OFFSET);
   // Command bits act only during the write access cycle and are not stored
   assign ctrl_write = access && i_pwrite && hit_control;
   assign clock_gen_enable_cmd = i_pwdata[`ARCC_CLK_ENABLE_BIT];
   assign clock_gen_disable_cmd = i_pwdata[`ARCC_CLK_DISABLE_BIT];
   assign receiver_enable_cmd = i_pwdata[`ARCC_RX_ENABLE_BIT];
   assign receiver_disable_cmd = i_pwdata[`ARCC_RX_DISABLE_BIT];

   // Clock generation state
   arcc_cmd_pair u_clk_pair (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_write(ctrl_write),
      .i_enable_cmd(clock_gen_enable_cmd),
      .i_disable_cmd(clock_gen_disable_cmd),
      .o_state(clk_state)
   );

   // Receiver state; the flag follows it directly
   arcc_cmd_pair u_rx_pair (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_write(ctrl_write),
      .i_enable_cmd(receiver_enable_cmd),
      .i_disable_cmd(receiver_disable_cmd),
      .o_state(rx_state)
   );

   assign status_word = {30'h0000_0000, clk_state, rx_state};
   assign rd_status = access && !i_pwrite && hit_status;
   assign rd_control = access && !i_pwrite && hit_control;
   assign wr_status = access && i_pwrite && hit_status;

   // Control is write-only: reads of it return zero
   assign prdata_next = rd_status ? status_word : 32'h0000_0000;

   // Anything but a control write or a status read answers with an error
   assign pslverr_next = access && !ctrl_write && !rd_status;

   // Zero wait state: answer is the access cycle itself
   assign o_pready = 1'b1;
   assign o_prdata = prdata_next;
   assign o_pslverr = pslverr_next;
   assign o_clock_gen_active = clk_state;
   assign o_receiver_active_flag = rx_state;

   AST_ZERO_NO_EFFECT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ctrl_write && (i_pwdata[3:0] == 4'h0) |=> $stable(clk_state) && $stable(rx_state))
      else $error("zero write changed a state");
   AST_CLK_DISABLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ctrl_write && clock_gen_disable_cmd |=> !o_clock_gen_active)
      else $error("clock generation not stopped");
   AST_CLK_ENABLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ctrl_write && clock_gen_enable_cmd && !clock_gen_disable_cmd |=> o_clock_gen_active)
      else $error("clock generation not started");
   AST_RX_DISABLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ctrl_write && receiver_disable_cmd |=> !o_receiver_active_flag)
      else $error("receiver flag not cleared");
   AST_RX_ENABLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ctrl_write && receiver_enable_cmd && !receiver_disable_cmd |=> o_receiver_active_flag)
      else $error("receiver not activated");
   AST_FLAG_TRACKS: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      $rose(o_receiver_active_flag) |-> $past(ctrl_write) && $past(receiver_enable_cmd))
      else $error("flag rose without enable");
   AST_STATUS_READ: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      access && !i_pwrite && hit_status |-> o_prdata[`ARCC_RX_ACTIVE_BIT] == rx_state)
      else $error("status read mismatch");
   AST_CONTROL_READS_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      access && !i_pwrite && hit_control |-> o_prdata == 32'h0000_0000)
      else $error("control read not zero");

   // Bus answer checks
   AST_PREADY_HIGH: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      o_pready)
      else $error("ready not high");

   AST_PRDATA_IDLE_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      !access |-> o_prdata == 32'h0000_0000)
      else $error("read data outside access");

   AST_PSLVERR_IDLE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      !access |-> !o_pslverr)
      else $error("error outside access");

   AST_CTRL_WRITE_OK: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ctrl_write |-> !o_pslverr)
      else $error("control write refused");

   AST_CTRL_READ_ERR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      rd_control |-> o_pslverr)
      else $error("control read not flagged");

   AST_STATUS_WRITE_ERR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      wr_status |-> o_pslverr)
      else $error("status write not flagged");

   AST_BAD_ADDR_ERR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      access && !hit_control && !hit_status |-> o_pslverr)
      else $error("unmapped access not flagged");

   // Status word layout
   AST_STATUS_CLK_BIT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      rd_status |-> o_prdata[`ARCC_CLK_ACTIVE_BIT] == clk_state)
      else $error("status clock bit mismatch");

   AST_STATUS_UPPER_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      rd_status |-> o_prdata[31:2] == 30'h0000_0000)
      else $error("status upper bits not zero");

   // Apart from reset, states move only on a control write
   AST_STATUS_WRITE_NO_EFFECT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      wr_status |=> $stable(clk_state) && $stable(rx_state))
      else $error("status write changed a state");

   AST_NO_WRITE_HOLDS: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      !ctrl_write |=> $stable(clk_state) && $stable(rx_state))
      else $error("state changed without a write");

   AST_CLK_FELL_CAUSE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      $fell(o_clock_gen_active) && !$past(i_reset) |-> $past(ctrl_write) && $past(clock_gen_disable_cmd))
      else $error("clock generation stopped without disable");

   AST_CLK_ROSE_CAUSE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      $rose(o_clock_gen_active) |-> $past(ctrl_write) && !$past(clock_gen_disable_cmd))
      else $error("clock generation started while disabled");

   AST_RX_FELL_CAUSE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      $fell(o_receiver_active_flag) && !$past(i_reset) |-> $past(ctrl_write) && $past(receiver_disable_cmd))
      else $error("receiver stopped without disable");

   AST_RX_ROSE_CAUSE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      $rose(o_receiver_active_flag) |-> !$past(receiver_disable_cmd))
      else $error("receiver activated while disabled");

   // Reset clears both held states
   AST_RESET_CLEARS: assert property (@(posedge i_sys_clk)
      i_reset |=> !o_clock_gen_active && !o_receiver_active_flag)
      else $error("reset did not clear states");

   COV_RX_ON: cover property (@(posedge i_sys_clk) disable iff (i_reset) $rose(rx_state));
   COV_RX_OFF: cover property (@(posedge i_sys_clk) disable iff (i_reset) $fell(rx_state));
   COV_CLK_BOTH: cover property (@(posedge i_sys_clk) disable iff (i_reset)
      ctrl_write && clock_gen_enable_cmd && clock_gen_disable_cmd);
   COV_ERR: cover property (@(posedge i_sys_clk) disable iff (i_reset) o_pslverr);
endmodule

// >>> audio_rx_clock_control_tb.sv
`timescale 1ns/100ps
module audio_rx_clock_control_tb;
   logic i_sys_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0;
   logic o_pready, o_pslverr, o_clock_gen_active, o_receiver_active_flag, err;
   logic [31:0] o_prdata, rd;
   logic [15:0] frames;
   logic [15:0] f0;
   int bad_count = 0;
   int cmp_count = 0;
   logic [3:0] cmd [8] = '{4'h1, 4'h0, 4'h4, 4'hc, 4'h4, 4'h3, 4'h5, 4'h8};
   logic [1:0] st_exp [8] = '{2'h1, 2'h1, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3, 2'h1};
   always #5 i_sys_clk = ~i_sys_clk;
   arcc_top dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_clock_gen_active(o_clock_gen_active),
      .o_receiver_active_flag(o_receiver_active_flag));
   arcc_codec_model partner (.i_sys_clk(i_sys_clk), .i_clock_gen_active(o_clock_gen_active),
      .i_receiver_active_flag(o_receiver_active_flag), .o_frames(frames));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_sys_clk);
      i_penable <= 1'b1;
      @(posedge i_sys_clk);
      while (o_pready !== 1'b1) @(posedge i_sys_clk);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #20000;
      bad_count++;
      $display("unexpected at %0t: run hung", $time);
      wrap_up;
   end
   initial begin
      repeat (2) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      xfer(1'b0, 12'h004, 32'h0);
      check(rd, 32'h0);
      foreach (cmd[k]) begin
         xfer(1'b1, 12'h000, {28'h0, cmd[k]});
         check({31'h0, err}, 32'h0);
         xfer(1'b0, 12'h004, 32'h0);
         check(rd, {30'h0, st_exp[k]});
         check({31'h0, o_clock_gen_active}, {31'h0, st_exp[k][1]});
      end
      $display("test command sequence done");
      xfer(1'b0, 12'h000, 32'h0);
      check(rd, 32'h0);
      check({31'h0, err}, 32'h1);
      xfer(1'b1, 12'h004, 32'hf);
      check({31'h0, err}, 32'h1);
      xfer(1'b1, 12'h008, 32'h4);
      check({31'h0, err}, 32'h1);
      xfer(1'b0, 12'h004, 32'h0);
      check(rd, 32'h1);
      check({31'h0, o_receiver_active_flag}, 32'h1);
      $display("test refused accesses done");
      xfer(1'b1, 12'h000, 32'h4);
      xfer(1'b0, 12'h004, 32'h0);
      check(rd, 32'h3);
      f0 = frames;
      xfer(1'b0, 12'h004, 32'h0);
      check({31'h0, frames == f0}, 32'h0);
      xfer(1'b1, 12'h000, 32'h8);
      xfer(1'b0, 12'h004, 32'h0);
      f0 = frames;
      xfer(1'b0, 12'h004, 32'h0);
      check({31'h0, frames != f0}, 32'h0);
      $display("test partner streaming done");
      xfer(1'b1, 12'h000, 32'h4);
      @(posedge i_sys_clk);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      check({30'h0, o_clock_gen_active, o_receiver_active_flag}, 32'h0);
      xfer(1'b0, 12'h004, 32'h0);
      check(rd, 32'h0);
      xfer(1'b1, 12'h000, 32'h1);
      xfer(1'b0, 12'h004, 32'h0);
      check(rd, 32'h1);
      $display("test mid-run reset done");
      wrap_up;
   end
endmodule
